// >>> core/dsam_map.vh
`ifndef DSAM_MAP_VH
`define DSAM_MAP_VH
// Byte addresses of the low byte of each 16-bit register; the high byte is at +1.
`define DSAM_ADDR_XRATE 7'h04
`define DSAM_ADDR_THR1 7'h26
`define DSAM_ADDR_THR2 7'h28
`define DSAM_ADDR_CNT1 7'h2a
`define DSAM_ADDR_CNT2 7'h2c
`define DSAM_ADDR_ACTRL 7'h2e
`define DSAM_ADDR_MISC 7'h34
`define DSAM_ADDR_PERIOD 7'h36
`define DSAM_ADDR_RANGE 7'h38
`define DSAM_ADDR_STATUS 7'h3c
// Reset values.
`define DSAM_RST_MISC 16'h0006
`define DSAM_RST_RANGE 16'h0402
`define DSAM_RST_PERIOD 16'h0001
`define DSAM_RST_ZERO 16'h0000
// Read-back masks: unused register bits always read as zero.
`define DSAM_THR_RD_MASK 16'hbfff
`define DSAM_ACTRL_RD_MASK 16'hffd7
// Diagnostic status bit positions.
`define DSAM_ST_ACC_LO 13
`define DSAM_ST_GYR_LO 10
`define DSAM_ST_ALM_LO 8
`define DSAM_ST_FLASH 6
`define DSAM_ST_DIAG 5
`define DSAM_ST_OVR 4
`define DSAM_ST_COMM 3
`define DSAM_ST_FUPD 2
`define DSAM_ST_HIGH 1
`define DSAM_ST_LOW 0
// Misc control bit positions.
`define DSAM_MC_MEM 11
`define DSAM_MC_SELF 10
`define DSAM_MC_NEG 9
`define DSAM_MC_POS 8
// Alarm control bit positions.
`define DSAM_AC_SRC2_HI 15
`define DSAM_AC_SRC2_LO 12
`define DSAM_AC_SRC1_HI 11
`define DSAM_AC_SRC1_LO 8
`define DSAM_AC_ROC_LO 6
`define DSAM_AC_FILT 4
`define DSAM_AC_OUT_EN 2
`define DSAM_AC_OUT_POL 1
`define DSAM_AC_OUT_SEL 0
// Threshold fields.
`define DSAM_TH_DIR 15
`define DSAM_TH_MSB 13
// Field widths.
`define DSAM_SRC_W 4
`define DSAM_DAT_W 14
`define DSAM_CNT_W 8
`endif

// >>> core/dsam_monitor.v
`timescale 1ns/1ns
`default_nettype none
`include "dsam_map.vh"

module dsam_monitor #(
    parameter SMPL_BASE = 1000
) (
    // Clock and reset.
    input wire CLK_SYS,
    input wire RST_B,
    // Register port: byte writes, word reads.
    input wire REG_WR,
    input wire REG_RD,
    input wire [6:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [15:0] REG_RDATA,
    // Condition inputs from the sensor datapath, same clock.
    input wire OVERRANGE,
    input wire COMM_FAIL,
    input wire FLASH_UPD_FAIL,
    input wire [15:0] X_RATE,
    // Supply comparator pins, asynchronous.
    input wire SUPPLY_HIGH,
    input wire SUPPLY_LOW,
    // Self-test and memory-test handshake with the datapath.
    output wire SELF_START,
    input wire SELF_DONE,
    input wire [5:0] SELF_FAIL,
    input wire SELF_DIAG_ERR,
    output wire MEM_START,
    input wire MEM_DONE,
    input wire MEM_FAIL,
    output wire STIM_NEG,
    output wire STIM_POS,
    output wire [15:0] RANGE_FILTER,
    // Alarm sources: selection goes out, selected data comes back.
    output wire [3:0] ALARM1_SRC,
    output wire [3:0] ALARM2_SRC,
    output wire ALARM_FILT,
    input wire [13:0] ALARM1_DATA,
    input wire [13:0] ALARM2_DATA,
    // Alarm indicator on the two general lines.
    output wire GENERAL_LINE_ONE_O,
    output wire GENERAL_LINE_ONE_OE,
    output wire GENERAL_LINE_TWO_O,
    output wire GENERAL_LINE_TWO_OE,
    // Sample cycle enable.
    output reg SAMPLE_TICK
);

    reg [15:0] thr_r [0:1];
    reg [15:0] cnt_set_r [0:1];
    reg [15:0] actrl_r;
    reg [15:0] misc_r;
    reg [15:0] period_r;
    reg [15:0] range_r;
    reg [15:0] flags_r;
    reg [15:0] flags_nxt;
    reg [5:0] self_res_r;
    reg self_diag_r;
    reg mem_res_r;
    reg self_go_r;
    reg mem_go_r;
    reg [2:0] hi_sync_r;
    reg [2:0] lo_sync_r;
    reg sup_hi_r;
    reg sup_lo_r;
    reg [15:0] base_cnt_r;
    reg [7:0] per_cnt_r;
    wire [1:0] alarm_act;
    wire stat_rd;
    wire [6:0] word_addr;
    wire alarm_any;
    wire alarm_lvl;

    // Word-aligned view of the byte address used for both reads and writes.
    assign word_addr = {REG_ADDR[6:1], 1'b0};
    assign stat_rd = REG_RD && (word_addr == `DSAM_ADDR_STATUS);

    // Writes land in one byte lane; the test-start bits also raise a start pulse.
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            thr_r[0] <= `DSAM_RST_ZERO;
            thr_r[1] <= `DSAM_RST_ZERO;
            cnt_set_r[0] <= `DSAM_RST_ZERO;
            cnt_set_r[1] <= `DSAM_RST_ZERO;
            actrl_r <= `DSAM_RST_ZERO;
            misc_r <= `DSAM_RST_MISC;
            period_r <= `DSAM_RST_PERIOD;
            range_r <= `DSAM_RST_RANGE;
            self_go_r <= 1'b0;
            mem_go_r <= 1'b0;
        end else begin
            self_go_r <= 1'b0;
            mem_go_r <= 1'b0;
            if (REG_WR) begin
                case (word_addr)
                    `DSAM_ADDR_THR1: begin
                        if (REG_ADDR[0]) thr_r[0][15:8] <= REG_WDATA;
                        else thr_r[0][7:0] <= REG_WDATA;
                    end
                    `DSAM_ADDR_THR2: begin
                        if (REG_ADDR[0]) thr_r[1][15:8] <= REG_WDATA;
                        else thr_r[1][7:0] <= REG_WDATA;
                    end
                    `DSAM_ADDR_CNT1: begin
                        if (!REG_ADDR[0]) cnt_set_r[0][7:0] <= REG_WDATA;
                    end
                    `DSAM_ADDR_CNT2: begin
                        if (!REG_ADDR[0]) cnt_set_r[1][7:0] <= REG_WDATA;
                    end
                    `DSAM_ADDR_ACTRL: begin
                        if (REG_ADDR[0]) actrl_r[15:8] <= REG_WDATA;
                        else actrl_r[7:0] <= REG_WDATA;
                    end
                    `DSAM_ADDR_MISC: begin
                        if (REG_ADDR[0]) begin
                            misc_r[11:8] <= REG_WDATA[3:0];
                            self_go_r <= REG_WDATA[`DSAM_MC_SELF - 8] && !misc_r[`DSAM_MC_SELF];
                            mem_go_r <= REG_WDATA[`DSAM_MC_MEM - 8] && !misc_r[`DSAM_MC_MEM];
                        end else begin
                            misc_r[7:0] <= REG_WDATA;
                        end
                    end
                    `DSAM_ADDR_PERIOD: begin
                        if (!REG_ADDR[0]) period_r[7:0] <= REG_WDATA;
                    end
                    `DSAM_ADDR_RANGE: begin
                        if (REG_ADDR[0]) range_r[10:8] <= REG_WDATA[2:0];
                        else range_r[2:0] <= REG_WDATA[2:0];
                    end
                    default: begin
                    end
                endcase
            end
            // A finished test drops its own request bit.
            if (SELF_DONE) misc_r[`DSAM_MC_SELF] <= 1'b0;
            if (MEM_DONE) misc_r[`DSAM_MC_MEM] <= 1'b0;
        end
    end

    assign SELF_START = self_go_r;
    assign MEM_START = mem_go_r;
    assign STIM_NEG = misc_r[`DSAM_MC_NEG];
    assign STIM_POS = misc_r[`DSAM_MC_POS];
    assign RANGE_FILTER = range_r;

    // Test results are held so a failure keeps re-flagging after each read.
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            self_res_r <= 6'h00;
            self_diag_r <= 1'b0;
            mem_res_r <= 1'b0;
        end else begin
            if (SELF_DONE) begin
                self_res_r <= SELF_FAIL;
                self_diag_r <= SELF_DIAG_ERR;
            end
            if (MEM_DONE) mem_res_r <= MEM_FAIL;
        end
    end

    // Supply comparators are asynchronous; a change is taken once two stages agree.
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            hi_sync_r <= 3'h0;
            lo_sync_r <= 3'h0;
            sup_hi_r <= 1'b0;
            sup_lo_r <= 1'b0;
        end else begin
            hi_sync_r <= {hi_sync_r[1:0], SUPPLY_HIGH};
            lo_sync_r <= {lo_sync_r[1:0], SUPPLY_LOW};
            if (hi_sync_r[2] == hi_sync_r[1]) sup_hi_r <= hi_sync_r[2];
            if (lo_sync_r[2] == lo_sync_r[1]) sup_lo_r <= lo_sync_r[2];
        end
    end

    // Sample cycle: a base divider times the programmed period, zero taken as one.
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            base_cnt_r <= 16'h0000;
            per_cnt_r <= 8'h00;
            SAMPLE_TICK <= 1'b0;
        end else begin
            SAMPLE_TICK <= 1'b0;
            if (base_cnt_r >= SMPL_BASE[15:0] - 16'h0001) begin
                base_cnt_r <= 16'h0000;
                if (per_cnt_r + 8'h01 >= period_r[7:0]) begin
                    per_cnt_r <= 8'h00;
                    SAMPLE_TICK <= 1'b1;
                end else begin
                    per_cnt_r <= per_cnt_r + 8'h01;
                end
            end else begin
                base_cnt_r <= base_cnt_r + 16'h0001;
            end
        end
    end

    // Threshold compare: direction bit picks greater-than or less-than, signed.
    function cmp_hit;
        input [15:0] thr;
        input signed [14:0] val;
        reg signed [14:0] lvl;
        begin
            lvl = {thr[`DSAM_TH_MSB], thr[`DSAM_TH_MSB:0]};
            cmp_hit = thr[`DSAM_TH_DIR] ? (val > lvl) : (val < lvl);
        end
    endfunction

    // Each alarm keeps its own reference sample and window counter.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : alm
            reg [13:0] ref_r;
            reg [7:0] win_r;
            reg act_r;
            wire [13:0] dat = (g == 0) ? ALARM1_DATA : ALARM2_DATA;
            wire [3:0] src = (g == 0) ? actrl_r[`DSAM_AC_SRC1_HI:`DSAM_AC_SRC1_LO] :
                actrl_r[`DSAM_AC_SRC2_HI:`DSAM_AC_SRC2_LO];
            wire roc = actrl_r[`DSAM_AC_ROC_LO + g];
            wire [14:0] delta = {dat[13], dat} - {ref_r[13], ref_r};
            always @(posedge CLK_SYS or negedge RST_B) begin
                if (!RST_B) begin
                    ref_r <= 14'h0000;
                    win_r <= 8'h00;
                    act_r <= 1'b0;
                end else if (src == 4'h0) begin
                    act_r <= 1'b0;
                    win_r <= 8'h00;
                end else if (SAMPLE_TICK) begin
                    if (!roc) begin
                        act_r <= cmp_hit(thr_r[g], {dat[13], dat});
                    end else if (win_r == 8'h00) begin
                        // Window of count samples; a zero count acts as one.
                        act_r <= cmp_hit(thr_r[g], delta);
                        ref_r <= dat;
                        win_r <= (cnt_set_r[g][7:0] == 8'h00) ? 8'h00 :
                            cnt_set_r[g][7:0] - 8'h01;
                    end else begin
                        win_r <= win_r - 8'h01;
                    end
                end
            end
            assign alarm_act[g] = act_r;
        end
    endgenerate

    assign ALARM1_SRC = actrl_r[`DSAM_AC_SRC1_HI:`DSAM_AC_SRC1_LO];
    assign ALARM2_SRC = actrl_r[`DSAM_AC_SRC2_HI:`DSAM_AC_SRC2_LO];
    assign ALARM_FILT = actrl_r[`DSAM_AC_FILT];

    // Flags: a clearing read zeroes them, but a set in the same cycle wins.
    always @* begin
        flags_nxt = stat_rd ? 16'h0000 : flags_r;
        if (SAMPLE_TICK) begin
            flags_nxt[15:13] = flags_nxt[15:13] | self_res_r[5:3];
            flags_nxt[12:10] = flags_nxt[12:10] | self_res_r[2:0];
            flags_nxt[9:8] = flags_nxt[9:8] | alarm_act;
            flags_nxt[`DSAM_ST_FLASH] = flags_nxt[`DSAM_ST_FLASH] | mem_res_r;
            flags_nxt[`DSAM_ST_DIAG] = flags_nxt[`DSAM_ST_DIAG] | self_diag_r;
            flags_nxt[`DSAM_ST_OVR] = flags_nxt[`DSAM_ST_OVR] | OVERRANGE;
            flags_nxt[`DSAM_ST_COMM] = flags_nxt[`DSAM_ST_COMM] | COMM_FAIL;
            flags_nxt[`DSAM_ST_FUPD] = flags_nxt[`DSAM_ST_FUPD] | FLASH_UPD_FAIL;
        end
        // Fresh test results show at once rather than waiting for the next sample.
        if (SELF_DONE) begin
            flags_nxt[15:10] = flags_nxt[15:10] | SELF_FAIL;
            flags_nxt[`DSAM_ST_DIAG] = flags_nxt[`DSAM_ST_DIAG] | SELF_DIAG_ERR;
        end
        if (MEM_DONE) flags_nxt[`DSAM_ST_FLASH] = flags_nxt[`DSAM_ST_FLASH] | MEM_FAIL;
        flags_nxt[7] = 1'b0;
        // Supply flags follow the comparators directly.
        flags_nxt[`DSAM_ST_HIGH] = sup_hi_r;
        flags_nxt[`DSAM_ST_LOW] = sup_lo_r;
    end

    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) flags_r <= 16'h0000;
        else flags_r <= flags_nxt;
    end

    // Read data is registered; the status read returns the value before clearing.
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            case (word_addr)
                `DSAM_ADDR_XRATE: REG_RDATA <= X_RATE;
                `DSAM_ADDR_THR1: REG_RDATA <= thr_r[0] & `DSAM_THR_RD_MASK;
                `DSAM_ADDR_THR2: REG_RDATA <= thr_r[1] & `DSAM_THR_RD_MASK;
                `DSAM_ADDR_CNT1: REG_RDATA <= cnt_set_r[0];
                `DSAM_ADDR_CNT2: REG_RDATA <= cnt_set_r[1];
                `DSAM_ADDR_ACTRL: REG_RDATA <= actrl_r & `DSAM_ACTRL_RD_MASK;
                `DSAM_ADDR_MISC: REG_RDATA <= misc_r;
                `DSAM_ADDR_PERIOD: REG_RDATA <= period_r;
                `DSAM_ADDR_RANGE: REG_RDATA <= range_r;
                `DSAM_ADDR_STATUS: REG_RDATA <= flags_r;
                default: REG_RDATA <= 16'h0000;
            endcase
        end
    end

    // Alarm indicator: either alarm asserts it; pin driven only when enabled.
    assign alarm_any = |alarm_act;
    assign alarm_lvl = actrl_r[`DSAM_AC_OUT_POL] ? alarm_any : ~alarm_any;
    assign GENERAL_LINE_TWO_OE = actrl_r[`DSAM_AC_OUT_EN] && actrl_r[`DSAM_AC_OUT_SEL];
    assign GENERAL_LINE_ONE_OE = actrl_r[`DSAM_AC_OUT_EN] && !actrl_r[`DSAM_AC_OUT_SEL];
    assign GENERAL_LINE_TWO_O = GENERAL_LINE_TWO_OE & alarm_lvl;
    assign GENERAL_LINE_ONE_O = GENERAL_LINE_ONE_OE & alarm_lvl;

endmodule
`default_nettype wire

// >>> verif/dsam_dp_model.sv
`timescale 1ns/1ns
`default_nettype none
module dsam_dp_model (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // Test requests and stimulus from the monitor.
    input wire logic SELF_START,
    input wire logic MEM_START,
    input wire logic STIM_NEG,
    input wire logic STIM_POS,
    // Results chosen by the bench.
    input wire logic [5:0] fail_cfg,
    input wire logic mem_cfg,
    // Answers to the monitor.
    output logic SELF_DONE,
    output logic [5:0] SELF_FAIL,
    output logic SELF_DIAG_ERR,
    output logic MEM_DONE,
    output logic MEM_FAIL,
    output logic [15:0] X_RATE
);
    logic [3:0] self_cnt_r;
    logic [3:0] mem_cnt_r;
    // Each test takes a few cycles, so the busy bit is seen before it clears.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            self_cnt_r <= 4'h0;
            mem_cnt_r <= 4'h0;
            SELF_DONE <= 1'b0;
            MEM_DONE <= 1'b0;
        end else begin
            SELF_DONE <= (self_cnt_r == 4'h1);
            MEM_DONE <= (mem_cnt_r == 4'h1);
            self_cnt_r <= SELF_START ? 4'h9 : self_cnt_r - {3'h0, self_cnt_r != 4'h0};
            mem_cnt_r <= MEM_START ? 4'h6 : mem_cnt_r - {3'h0, mem_cnt_r != 4'h0};
        end
    end
    // Results are valid only with their done pulse; otherwise they show the inverse.
    assign SELF_FAIL = SELF_DONE ? fail_cfg : ~fail_cfg;
    // A diagnostic error is reported with the done pulse and is low otherwise.
    assign SELF_DIAG_ERR = SELF_DONE;
    assign MEM_FAIL = MEM_DONE ? mem_cfg : ~mem_cfg;
    // The rate output moves by a fixed step under each stimulus.
    assign X_RATE = 16'h0100 + (STIM_POS ? 16'h0040 : 16'h0000) - (STIM_NEG ? 16'h0040 : 16'h0000);
endmodule
`default_nettype wire

// >>> verif/dsam_monitor_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dsam_monitor_chk #(
    parameter SMPL_BASE = 1000
) (
    // Clock, reset and register port.
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    // Handshakes, pins and the sample cycle.
    input wire logic SELF_START,
    input wire logic SELF_DONE,
    input wire logic MEM_START,
    input wire logic MEM_DONE,
    input wire logic STIM_NEG,
    input wire logic STIM_POS,
    input wire logic GENERAL_LINE_ONE_OE,
    input wire logic GENERAL_LINE_TWO_OE,
    input wire logic SAMPLE_TICK
);
    logic [2:0] pin_r;
    logic [31:0] gap_r;
    logic seen_r;
    wire st_rd = REG_RD && (REG_ADDR[6:1] == 6'h1e);
    wire ev = SAMPLE_TICK || SELF_DONE || MEM_DONE;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Mirror of the pin bits and tick spacing; the sample period stays at one.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            pin_r <= 3'h0;
            gap_r <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            if (REG_WR && REG_ADDR == 7'h2e) begin
                pin_r <= REG_WDATA[2:0];
            end
            gap_r <= SAMPLE_TICK ? 32'h0 : gap_r + 32'h1;
            seen_r <= seen_r | SAMPLE_TICK;
        end
    end
    a_pin_one_enable: assert property (GENERAL_LINE_ONE_OE == (pin_r[2] && !pin_r[0]))
        else $error("line one enable wrong");
    a_pin_two_enable: assert property (GENERAL_LINE_TWO_OE == (pin_r[2] && pin_r[0]))
        else $error("line two enable wrong");
    a_neg_stim_write: assert property (
        REG_WR && REG_ADDR == 7'h35 |=> STIM_NEG == $past(REG_WDATA[1]))
        else $error("negative stimulus wrong");
    a_pos_stim_write: assert property (
        REG_WR && REG_ADDR == 7'h35 |=> STIM_POS == $past(REG_WDATA[0]))
        else $error("positive stimulus wrong");
    a_self_start_cause: assert property (
        SELF_START |-> $past(REG_WR) && $past(REG_ADDR) == 7'h35 && $past(REG_WDATA[2]))
        else $error("self test start without request");
    a_mem_start_cause: assert property (
        MEM_START |-> $past(REG_WR) && $past(REG_ADDR) == 7'h35 && $past(REG_WDATA[3]))
        else $error("memory test start without request");
    a_read_clears_flags: assert property (
        !ev ##1 (st_rd && !ev) ##1 (st_rd && !ev) |=> REG_RDATA[15:2] == 14'h0)
        else $error("flags not cleared by read");
    a_tick_spacing: assert property (SAMPLE_TICK && seen_r |-> gap_r == SMPL_BASE - 1)
        else $error("sample cycle spacing wrong");
endmodule
bind dsam_monitor dsam_monitor_chk #(.SMPL_BASE(SMPL_BASE)) i_chk (.CLK_SYS, .RST_B, .REG_WR,
    .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .SELF_START, .SELF_DONE, .MEM_START, .MEM_DONE,
    .STIM_NEG, .STIM_POS, .GENERAL_LINE_ONE_OE, .GENERAL_LINE_TWO_OE, .SAMPLE_TICK);
`default_nettype wire

// >>> verif/dsam_monitor_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dsam_monitor_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic ovr = 1'b0;
    logic comm = 1'b0;
    logic fupd = 1'b0;
    logic [1:0] sup = 2'h0;
    logic [13:0] a1 = 14'h0000;
    logic [13:0] a2 = 14'h0000;
    logic [15:0] r;
    logic [15:0] base;
    int n_errors = 0;
    int checks = 0;
    wire [15:0] rdata;
    wire [15:0] x_rate;
    wire [5:0] self_fail;
    wire self_start, self_done, self_diag, mem_start, mem_done, mem_fail;
    wire stim_neg, stim_pos, tick, o1, oe1, o2, oe2;
    wire [15:0] range_flt;
    wire [3:0] src1, src2;
    wire filt;
    // Short sample cycle keeps the run brief.
    dsam_monitor #(.SMPL_BASE(4)) i_dut (.CLK_SYS(clk), .RST_B(rst_b), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .OVERRANGE(ovr), .COMM_FAIL(comm),
        .FLASH_UPD_FAIL(fupd), .X_RATE(x_rate), .SUPPLY_HIGH(sup[1]), .SUPPLY_LOW(sup[0]),
        .SELF_START(self_start), .SELF_DONE(self_done), .SELF_FAIL(self_fail),
        .SELF_DIAG_ERR(self_diag), .MEM_START(mem_start), .MEM_DONE(mem_done),
        .MEM_FAIL(mem_fail), .STIM_NEG(stim_neg), .STIM_POS(stim_pos),
        .RANGE_FILTER(range_flt), .ALARM1_SRC(src1), .ALARM2_SRC(src2), .ALARM_FILT(filt),
        .ALARM1_DATA(a1), .ALARM2_DATA(a2),
        .GENERAL_LINE_ONE_O(o1), .GENERAL_LINE_ONE_OE(oe1), .GENERAL_LINE_TWO_O(o2),
        .GENERAL_LINE_TWO_OE(oe2), .SAMPLE_TICK(tick));
    // Far side: fails accel Z, accel X and gyro X, the diagnostic, and the memory checksum.
    dsam_dp_model i_dp (.CLK_SYS(clk), .RST_B(rst_b), .SELF_START(self_start),
        .MEM_START(mem_start), .STIM_NEG(stim_neg), .STIM_POS(stim_pos), .fail_cfg(6'h29),
        .mem_cfg(1'b1), .SELF_DONE(self_done), .SELF_FAIL(self_fail), .SELF_DIAG_ERR(self_diag),
        .MEM_DONE(mem_done), .MEM_FAIL(mem_fail), .X_RATE(x_rate));
    // Free-running system clock.
    initial begin
        forever #5 clk = ~clk;
    end
    // Verdict and end of run.
    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Masked word comparison.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        checks++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h mask %h", $time, got, exp, m);
        end
    endtask
    // Byte write; strobe drops a cycle before any next request.
    task automatic wrb(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // Word read; data is settled by the next falling edge.
    task automatic rdw(input logic [6:0] a, output logic [15:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
    // Bounded wait for tick (0), self-test done (1) or memory done (2).
    task automatic wait_hi(input int s);
        int i;
        for (i = 0; i < 200; i++) begin
            @(negedge clk);
            if ((s == 0 && tick === 1'b1) || (s == 1 && self_done === 1'b1)) break;
            if (s == 2 && mem_done === 1'b1) break;
        end
        if (i == 200) begin
            n_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            tally_and_finish;
        end
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        rdw(7'h34, r);
        chk(r, 16'h0006, 16'hffff);
        rdw(7'h10, r);
        chk(r, 16'h0000, 16'hffff);
        // Host-driven stimulus sequence on the rate output.
        wrb(7'h36, 8'h01);
        wrb(7'h39, 8'h04);
        wrb(7'h38, 8'h02);
        rdw(7'h38, r);
        chk(r, 16'h0402, 16'hffff);
        chk(range_flt, 16'h0402, 16'hffff);
        rdw(7'h04, base);
        wrb(7'h35, 8'h02);
        rdw(7'h04, r);
        chk(r, base - 16'h0040, 16'hffff);
        wrb(7'h35, 8'h01);
        rdw(7'h04, r);
        chk(r, base + 16'h0040, 16'hffff);
        wrb(7'h35, 8'h00);
        // Self-running test reports per-axis results and clears its bit.
        wrb(7'h35, 8'h04);
        wait_hi(1);
        rdw(7'h34, r);
        chk(r, 16'h0006, 16'hffff);
        rdw(7'h3c, r);
        chk(r, 16'ha420, 16'hfc20);
        wrb(7'h35, 8'h08);
        wait_hi(2);
        rdw(7'h3c, r);
        chk(r, 16'h0040, 16'h0040);
        // Two reads clear of any tick: stored results come back, then all clear.
        wait_hi(0);
        repeat (2) @(negedge clk);
        rd = 1'b1;
        addr = 7'h3c;
        @(negedge clk);
        chk(rdata, 16'ha420, 16'hfc20);
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, 16'h0000, 16'hfffc);
        // A set landing with a clearing read must survive it.
        wait_hi(0);
        ovr = 1'b1;
        comm = 1'b1;
        fupd = 1'b1;
        rd = 1'b1;
        @(negedge clk);
        ovr = 1'b0;
        comm = 1'b0;
        fupd = 1'b0;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, 16'h001c, 16'h001c);
        // Supply flags follow the pins without a read.
        for (int i = 0; i < 2; i++) begin
            sup = 2'h2 >> i;
            repeat (8) @(negedge clk);
            rdw(7'h3c, r);
            chk(r, {14'h0, sup}, 16'h0003);
            sup = 2'h0;
            repeat (8) @(negedge clk);
            rdw(7'h3c, r);
            chk(r, 16'h0000, 16'h0003);
        end
        // Alarm one above 16, alarm two below 8, pin high on line one.
        wrb(7'h26, 8'h10);
        wrb(7'h27, 8'h80);
        wrb(7'h28, 8'h08);
        wrb(7'h29, 8'h00);
        a1 = 14'h0020;
        a2 = 14'h0010;
        wrb(7'h2e, 8'h06);
        wrb(7'h2f, 8'h11);
        wait_hi(0);
        wait_hi(0);
        chk({14'h0, oe1, o1}, 16'h0003, 16'h0003);
        rdw(7'h3c, r);
        chk(r, 16'h0100, 16'h0380);
        // Swap which alarm fires; active-low level on line two.
        a1 = 14'h0005;
        a2 = 14'h3ffd;
        wrb(7'h2e, 8'h05);
        wait_hi(0);
        wait_hi(0);
        rdw(7'h3c, r);
        wait_hi(0);
        chk({12'h0, oe2, o2, oe1, o1}, 16'h0008, 16'h000e);
        rdw(7'h3c, r);
        chk(r, 16'h0200, 16'h0300);
        // Rate mode on alarm one, two-sample window; the write is aligned to a tick so the
        // first window end is known. A steady input must drop the alarm after one window.
        a1 = 14'h0020;
        a2 = 14'h0010;
        wrb(7'h2a, 8'h02);
        wait_hi(0);
        wrb(7'h2e, 8'h7e);
        wait_hi(0);
        repeat (2) @(negedge clk);
        chk({15'h0, o1}, 16'h0001, 16'h0001);
        wait_hi(0);
        repeat (2) @(negedge clk);
        chk({15'h0, o1}, 16'h0001, 16'h0001);
        wait_hi(0);
        repeat (2) @(negedge clk);
        chk({15'h0, o1}, 16'h0000, 16'h0001);
        // Unused control bits read back as zero; source and filter fields reach the pins.
        rdw(7'h2e, r);
        chk(r, 16'h1156, 16'hffff);
        chk({7'h0, filt, src2, src1}, 16'h0111, 16'hffff);
        tally_and_finish;
    end
endmodule
`default_nettype wire
